/* tb/pfc_link_model.sv */
// Behavioural model of the port 1 transceiver and link partner state
module pfc_link_model (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rstn,
    // Link state request from the bench
    input  wire logic       set_link,
    input  wire logic [3:0] link_mode,
    // Link state seen by the switch port
    output logic            autoneg_on,
    output logic            half_duplex,
    output logic            an_rx_pause,
    output logic            an_tx_pause
);
    timeunit 1ns;
    timeprecision 1ps;

    // Link comes up negotiated, full duplex, no pause; then follows requests
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            {autoneg_on, half_duplex, an_rx_pause, an_tx_pause} <= 4'h8;
        end else if (set_link) begin
            {autoneg_on, half_duplex, an_rx_pause, an_tx_pause} <= link_mode;
        end
    end
endmodule

/* tb/pfc_regs_test.sv */
// Self-checking bench for the port 1 flow control register
module pfc_regs_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock, rstn, reg_wr, reg_rd, reg_rvalid;   // Clock, reset, strobes
    logic [11:0] reg_addr;                                  // Register address
    logic [31:0] reg_wdata, reg_rdata, wd;                  // Bus data, random word
    logic        bp_s, fd_s, man_s;                         // Strap pins
    logic        reload, rl_bp, rl_fd, rl_man;              // Loader rewrite
    logic        an, hd, anrx, antx;                        // Link state
    logic        bpa, rxa, txa;                             // Controls to the MAC
    logic        set_link;                                  // Link change request
    logic [3:0]  link_mode;                                 // Requested link state
    logic        bp, rx, tx, man;                           // Expected fields
    int          n_fail, n_checks;                          // Counters
    int          cycles = 0;                                // Cycles run, for the hang guard
    int          seed = 5180;                               // Fixed seed

    pfc_regs i_pfc_regs (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .port1_backpressure_strap(bp_s), .port1_full_duplex_pause_strap(fd_s),
        .port1_manual_select_strap(man_s), .port1_reload_strobe(reload),
        .port1_reload_backpressure(rl_bp), .port1_reload_full_duplex_pause(rl_fd),
        .port1_reload_manual_select(rl_man), .port1_autoneg_enable(an), .port1_half_duplex(hd),
        .port1_an_rx_pause(anrx), .port1_an_tx_pause(antx), .port1_backpressure_active(bpa),
        .port1_rx_pause_active(rxa), .port1_tx_pause_active(txa));

    pfc_link_model i_pfc_link_model (.clock(clock), .rstn(rstn), .set_link(set_link),
        .link_mode(link_mode), .autoneg_on(an), .half_duplex(hd), .an_rx_pause(anrx),
        .an_tx_pause(antx));

    // Expected register word from the fields and the link state
    function automatic logic [31:0] exp_word();
        logic r, t;
        r = rx;
        t = tx;
        if (link_mode[2]) begin
            // Half duplex: no pause in effect
            r = 1'b0;
            t = 1'b0;
        end else if (!man && link_mode[3]) begin
            // Negotiated result rules
            r = link_mode[1];
            t = link_mode[0];
        end
        return {25'h0, bp, link_mode[2], r, t, rx, tx, man};
    endfunction

    // Compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // One write cycle
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask

    // One read cycle, answer checked the cycle after the strobe
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1;
        check("rvalid", {31'h0, reg_rvalid}, 32'h1);
        check("rdata", reg_rdata, exp);
    endtask

    // Change the link state through the partner
    task automatic link(input logic [3:0] m);
        @(posedge clock);
        link_mode <= m;
        set_link  <= 1'b1;
        @(posedge clock);
        set_link  <= 1'b0;
    endtask

    // Let status settle, then check the MAC controls
    task automatic settle();
        logic [31:0] e;
        repeat (3) @(posedge clock);
        #1;
        e = exp_word();
        check("mac controls", {29'h0, bpa, rxa, txa}, {29'h0, bp & link_mode[2], e[4], e[3]});
    endtask

    // Clock generator
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // Hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            test_done();
        end
    end

    // Main sequence
    initial begin
        {rstn, reg_wr, reg_rd, reload, set_link} = 5'h0;
        {rl_bp, rl_fd, rl_man, reg_addr, reg_wdata} = '0;
        link_mode = 4'h8;
        {n_fail, n_checks} = '0;
        {bp_s, fd_s, man_s} = 3'($random(seed));
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        repeat (6) @(posedge clock);
        {bp, rx, tx, man} = {bp_s, fd_s, fd_s, man_s};
        rd_chk(pfc_pkg::FC_OFFSET, exp_word());
        $display("test reset defaults done");
        // Random words and link states; first sixteen cover every link mode
        for (int i = 0; i < 48; i++) begin
            wd = $random(seed);
            if (i < 16) begin
                link(i[3:0]);
            end else if (wd[9]) begin
                link(wd[13:10]);
            end
            wr(pfc_pkg::FC_OFFSET, wd);
            {bp, rx, tx, man} = {wd[6], wd[2], wd[1], wd[0]};
            settle();
            rd_chk(pfc_pkg::FC_OFFSET, exp_word());
        end
        $display("test random writes done");
        // Other address: write ignored, read gives zero
        wr(12'h1A4, ~exp_word());
        rd_chk(12'h1A4, 32'h0);
        rd_chk(pfc_pkg::FC_OFFSET, exp_word());
        $display("test unmapped done");
        // Loader rewrite wins over a write in the same cycle
        for (int i = 0; i < 4; i++) begin
            wd = $random(seed);
            @(posedge clock);
            {rl_bp, rl_fd, rl_man} <= wd[2:0];
            reload    <= 1'b1;
            reg_addr  <= pfc_pkg::FC_OFFSET;
            reg_wdata <= ~{25'h0, wd[2], 3'h0, wd[1], wd[1], wd[0]};
            reg_wr    <= 1'b1;
            @(posedge clock);
            reload    <= 1'b0;
            reg_wr    <= 1'b0;
            {bp, rx, tx, man} = {wd[2], wd[1], wd[1], wd[0]};
            settle();
            rd_chk(pfc_pkg::FC_OFFSET, exp_word());
        end
        $display("test loader rewrite done");
        test_done();
    end
endmodule

/* verilog/pfc_pkg.sv */
// Constants shared by the port 1 flow control register block
package pfc_pkg;
    // Register address
    localparam int          ADDR_W        = 12;
    localparam logic [11:0] FC_OFFSET     = 12'h1A0;
    // Field positions
    localparam int          BP_BIT        = 6;
    localparam int          DUP_BIT       = 5;
    localparam int          CUR_RX_BIT    = 4;
    localparam int          CUR_TX_BIT    = 3;
    localparam int          RX_BIT        = 2;
    localparam int          TX_BIT        = 1;
    localparam int          MAN_BIT       = 0;
    localparam int          RSVD_LSB      = 7;
    // Reset values before straps are taken
    localparam logic        FIELD_RST     = 1'b0;
    localparam logic [31:0] RDATA_RST     = 32'h0000_0000;
    // Cycles after reset release before synchronised straps are valid
    localparam logic [1:0]  STRAP_WAIT    = 2'h2;
    // Strap capture states
    typedef enum logic [1:0] {
        ST_WAIT = 2'b01,
        ST_RUN  = 2'b10
    } pfc_state_t;
endpackage

/* verilog/pfc_regs.sv */
// Port 1 flow control configuration and status register
module pfc_regs (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // System register access
    input  wire logic [11:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    output logic             reg_rvalid,
    // Configuration strap pins
    input  wire logic        port1_backpressure_strap,
    input  wire logic        port1_full_duplex_pause_strap,
    input  wire logic        port1_manual_select_strap,
    // Strap rewrite from the configuration loader
    input  wire logic        port1_reload_strobe,
    input  wire logic        port1_reload_backpressure,
    input  wire logic        port1_reload_full_duplex_pause,
    input  wire logic        port1_reload_manual_select,
    // Link state from the port 1 transceiver
    input  wire logic        port1_autoneg_enable,
    input  wire logic        port1_half_duplex,
    input  wire logic        port1_an_rx_pause,
    input  wire logic        port1_an_tx_pause,
    // Controls to the port 1 MAC
    output logic             port1_backpressure_active,
    output logic             port1_rx_pause_active,
    output logic             port1_tx_pause_active
);
    // Strap synchroniser stages
    logic [2:0]          strap_meta;
    logic [2:0]          strap_sync;
    // Capture sequencer
    pfc_pkg::pfc_state_t state;
    pfc_pkg::pfc_state_t next_state;
    logic [1:0]          wait_cnt;
    logic [1:0]          next_wait_cnt;
    // Writable fields
    logic                port1_backpressure_enable;
    logic                port1_rx_pause_enable;
    logic                port1_tx_pause_enable;
    logic                port1_manual_flow_select;
    logic                next_bp;
    logic                next_rx;
    logic                next_tx;
    logic                next_man;
    // Status fields
    logic                port1_current_duplex;
    logic                port1_current_rx_pause_enable;
    logic                port1_current_tx_pause_enable;
    logic                res_rx;
    logic                res_tx;
    logic                next_bp_active;
    // Read path
    logic [31:0]         next_rdata;
    logic                next_rvalid;
    logic                wr_hit;

    // Register address match
    assign wr_hit = reg_wr && (reg_addr == pfc_pkg::FC_OFFSET);

    // Two flops on the strap pins
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            strap_meta <= 3'h0;
            strap_sync <= 3'h0;
        end else begin
            strap_meta <= {port1_backpressure_strap, port1_full_duplex_pause_strap, port1_manual_select_strap};
            strap_sync <= strap_meta;
        end
    end

    // Sequencer and writable field next values
    always_comb begin
        next_state    = state;
        next_wait_cnt = wait_cnt;
        next_bp       = port1_backpressure_enable;
        next_rx       = port1_rx_pause_enable;
        next_tx       = port1_tx_pause_enable;
        next_man      = port1_manual_flow_select;
        case (state)
            pfc_pkg::ST_WAIT: begin
                // Wait for the synchronisers, then take the straps
                if (wait_cnt == pfc_pkg::STRAP_WAIT) begin
                    next_bp    = strap_sync[2];
                    next_rx    = strap_sync[1];
                    next_tx    = strap_sync[1];
                    next_man   = strap_sync[0];
                    next_state = pfc_pkg::ST_RUN;
                end else begin
                    next_wait_cnt = wait_cnt + 2'h1;
                end
            end
            pfc_pkg::ST_RUN: begin
                if (port1_reload_strobe) begin
                    // Loader rewrite takes precedence over a software write
                    next_bp  = port1_reload_backpressure;
                    next_rx  = port1_reload_full_duplex_pause;
                    next_tx  = port1_reload_full_duplex_pause;
                    next_man = port1_reload_manual_select;
                end else if (wr_hit) begin
                    // Only this block's fields; advertisement stays as is
                    next_bp  = reg_wdata[pfc_pkg::BP_BIT];
                    next_rx  = reg_wdata[pfc_pkg::RX_BIT];
                    next_tx  = reg_wdata[pfc_pkg::TX_BIT];
                    next_man = reg_wdata[pfc_pkg::MAN_BIT];
                end
            end
            default: begin
                next_state    = pfc_pkg::ST_WAIT;
                next_wait_cnt = 2'h0;
            end
        endcase
    end

    // Sequencer and writable field registers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state                     <= pfc_pkg::ST_WAIT;
            wait_cnt                  <= 2'h0;
            port1_backpressure_enable <= pfc_pkg::FIELD_RST;
            port1_rx_pause_enable     <= pfc_pkg::FIELD_RST;
            port1_tx_pause_enable     <= pfc_pkg::FIELD_RST;
            port1_manual_flow_select  <= pfc_pkg::FIELD_RST;
        end else begin
            state                     <= next_state;
            wait_cnt                  <= next_wait_cnt;
            port1_backpressure_enable <= next_bp;
            port1_rx_pause_enable     <= next_rx;
            port1_tx_pause_enable     <= next_tx;
            port1_manual_flow_select  <= next_man;
        end
    end

    // Pause resolution from the current fields and link state
    pfc_resolve u_resolve (
        .manual_sel  (port1_manual_flow_select),
        .rx_enable   (port1_rx_pause_enable),
        .tx_enable   (port1_tx_pause_enable),
        .autoneg_on  (port1_autoneg_enable),
        .half_duplex (port1_half_duplex),
        .an_rx_pause (port1_an_rx_pause),
        .an_tx_pause (port1_an_tx_pause),
        .rx_active   (res_rx),
        .tx_active   (res_tx)
    );

    // Backpressure only matters in half duplex
    assign next_bp_active = port1_backpressure_enable && port1_half_duplex;

    // Status registers; fed every cycle from the fields and link state; the fields hold reset values until the straps are taken
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            port1_current_duplex          <= pfc_pkg::FIELD_RST;
            port1_current_rx_pause_enable <= pfc_pkg::FIELD_RST;
            port1_current_tx_pause_enable <= pfc_pkg::FIELD_RST;
            port1_backpressure_active     <= pfc_pkg::FIELD_RST;
        end else begin
            port1_current_duplex          <= port1_half_duplex;
            port1_current_rx_pause_enable <= res_rx;
            port1_current_tx_pause_enable <= res_tx;
            port1_backpressure_active     <= next_bp_active;
        end
    end

    // Pause enables to the MAC are the reported ones
    assign port1_rx_pause_active = port1_current_rx_pause_enable;
    assign port1_tx_pause_active = port1_current_tx_pause_enable;

    // Read data assembly
    always_comb begin
        next_rdata  = pfc_pkg::RDATA_RST; // Reserved and unmapped read zero
        next_rvalid = reg_rd;
        if (reg_rd && (reg_addr == pfc_pkg::FC_OFFSET)) begin
            next_rdata[pfc_pkg::BP_BIT]     = port1_backpressure_enable;
            next_rdata[pfc_pkg::DUP_BIT]    = port1_current_duplex;
            next_rdata[pfc_pkg::CUR_RX_BIT] = port1_current_rx_pause_enable;
            next_rdata[pfc_pkg::CUR_TX_BIT] = port1_current_tx_pause_enable;
            next_rdata[pfc_pkg::RX_BIT]     = port1_rx_pause_enable;
            next_rdata[pfc_pkg::TX_BIT]     = port1_tx_pause_enable;
            next_rdata[pfc_pkg::MAN_BIT]    = port1_manual_flow_select;
        end
    end

    // Read data registers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reg_rdata  <= pfc_pkg::RDATA_RST;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata  <= next_rdata;
            reg_rvalid <= next_rvalid;
        end
    end

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    // Strap capture at the end of the wait
    sequence s_wait_end;
        state == pfc_pkg::ST_WAIT && wait_cnt == pfc_pkg::STRAP_WAIT;
    endsequence
    sequence s_run_entered;
        state == pfc_pkg::ST_RUN;
    endsequence

    chk_strap_load: assert property (s_wait_end |=> s_run_entered ##0
        port1_backpressure_enable == $past(strap_sync[2]) && port1_manual_flow_select == $past(strap_sync[0]))
        else $error("strap values not loaded");
    chk_loader_update: assert property (state == pfc_pkg::ST_RUN && port1_reload_strobe |=>
        port1_rx_pause_enable == $past(port1_reload_full_duplex_pause)
        && port1_backpressure_enable == $past(port1_reload_backpressure))
        else $error("loader rewrite not applied");
    chk_write_bp: assert property (state == pfc_pkg::ST_RUN && wr_hit && !port1_reload_strobe |=>
        port1_backpressure_enable == $past(reg_wdata[pfc_pkg::BP_BIT]) ##1
        port1_backpressure_active == ($past(port1_backpressure_enable) && $past(port1_half_duplex)))
        else $error("backpressure write or gating wrong");
    chk_dup_report: assert property (##1 port1_current_duplex == $past(port1_half_duplex))
        else $error("duplex status wrong");
    chk_half_no_pause: assert property (port1_current_duplex |->
        !port1_rx_pause_active && !port1_tx_pause_active)
        else $error("pause active in half duplex");
    chk_manual_rx: assert property (port1_manual_flow_select && !port1_half_duplex |=>
        port1_current_rx_pause_enable == $past(port1_rx_pause_enable))
        else $error("manual receive pause wrong");
    chk_an_result: assert property (!port1_manual_flow_select && port1_autoneg_enable
        && !port1_half_duplex |=> port1_current_tx_pause_enable == $past(port1_an_tx_pause))
        else $error("negotiated pause not used");
    chk_an_off_tx: assert property (!port1_manual_flow_select && !port1_autoneg_enable
        && !port1_half_duplex |=> port1_current_tx_pause_enable == $past(port1_tx_pause_enable))
        else $error("manual transmit pause wrong");
    chk_reserved_zero: assert property (reg_rvalid |-> reg_rdata[31:pfc_pkg::RSVD_LSB] == 25'h0)
        else $error("reserved bits not zero");
endmodule

/* verilog/pfc_resolve.sv */
// Resolves the pause enables actually in effect on port 1
module pfc_resolve (
    // Configuration fields
    input  wire logic manual_sel,
    input  wire logic rx_enable,
    input  wire logic tx_enable,
    // Link state from the transceiver
    input  wire logic autoneg_on,
    input  wire logic half_duplex,
    input  wire logic an_rx_pause,
    input  wire logic an_tx_pause,
    // Resolved result
    output logic      rx_active,
    output logic      tx_active
);
    // Choose source of the pause enables
    always_comb begin
        if (half_duplex) begin
            // No pause frames in half duplex
            rx_active = 1'b0;
            tx_active = 1'b0;
        end else if (!manual_sel && autoneg_on) begin
            // Negotiated result, enable bits ignored
            rx_active = an_rx_pause;
            tx_active = an_tx_pause;
        end else begin
            // Manual or negotiation off: enable bits
            rx_active = rx_enable;
            tx_active = tx_enable;
        end
    end
endmodule
